// file: hw/boundary_scan_tap_registers.v
// boundary-scan instruction and data registers with core-side controls
`timescale 1ns/1ps
`include "tap_defs.vh"
module boundary_scan_tap_registers #(
	parameter              PIN_COUNT    = 8,
	parameter              ANA_COUNT    = 2,
	parameter        [3:0] ID_VERSION   = 4'h0,    // arbitrary value
	parameter       [15:0] ID_PART      = 16'h5A3C, // arbitrary value
	parameter       [10:0] ID_MAKER     = 11'h2B5,  // arbitrary value
	parameter       [23:0] TO_SHORT_CYC = `TO_SHORT_US * `CORE_CLK_MHZ,
	parameter       [23:0] TO_LONG_CYC  = `TO_LONG_US * `CORE_CLK_MHZ
) (
	input  wire                 core_clk,
	input  wire                 srst,
	input  wire                 tck,
	input  wire                 tms,
	input  wire                 tdi,
	output reg                  tdo,
	output reg                  tdoOe,
	input  wire                 tapEnableFuse,
	input  wire                 lockBitOne,
	input  wire                 lockBitTwo,
	input  wire                 chipErase,
	input  wire                 debugFuseProgram,
	input  wire                 timeoutFuseLong,
	input  wire [1:0]           regAddr,
	input  wire [7:0]           regWdata,
	input  wire                 regWr,
	input  wire                 regRd,
	output reg  [7:0]           regRdata,
	input  wire [PIN_COUNT-1:0] pinIn,
	input  wire [PIN_COUNT-1:0] coreOut,
	input  wire [PIN_COUNT-1:0] coreOe,
	output reg  [PIN_COUNT-1:0] pinOut,
	output reg  [PIN_COUNT-1:0] pinOe,
	output reg                  pullupDisable,
	input  wire [ANA_COUNT-1:0] anaIn,
	input  wire [ANA_COUNT-1:0] coreAna,
	output reg  [ANA_COUNT-1:0] anaOut,
	output reg                  coreReset,
	output reg                  debugEnableFuse,
	output reg                  debugFuseRefused
);
	localparam BS_LEN = 2 * PIN_COUNT + ANA_COUNT;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function [1:0] drSelect;
		input [`IR_W-1:0] op;
		begin
			case (op)
			`OP_EXTEST:   drSelect = `DR_BS;
			`OP_SAMPLE:   drSelect = `DR_BS;
			`OP_IDCODE:   drSelect = `DR_ID;
			`OP_RSTCHAIN: drSelect = `DR_RST;
			default:      drSelect = `DR_BYP;
			endcase
		end
	endfunction

	// ----------------------------------------
	// link sampling
	// ----------------------------------------
	// limitation: scan needs core_clk running, the test clock is only sampled
	wire [2:0]           linkSync;
	wire [PIN_COUNT-1:0] pinSync;
	wire [ANA_COUNT-1:0] anaSync;
	reg                  tckLast_reg;
	wire                 tckS = linkSync[0];
	wire                 tmsS = linkSync[1];
	wire                 tdiS = linkSync[2];
	wire                 tckRise = tckS & ~tckLast_reg;
	wire                 tckFall = ~tckS & tckLast_reg;

	tap_sync #(.WIDTH(3)) linkSyncInst (
		.core_clk (core_clk),
		.srst     (srst),
		.d        ({tdi, tms, tck}),
		.q        (linkSync)
	);

	tap_sync #(.WIDTH(PIN_COUNT + ANA_COUNT)) pinSyncInst (
		.core_clk (core_clk),
		.srst     (srst),
		.d        ({anaIn, pinIn}),
		.q        ({anaSync, pinSync})
	);

	always @(posedge core_clk) begin
		if (srst) begin
			tckLast_reg <= 1'b0;
		end else begin
			tckLast_reg <= tckS;
		end
	end

	// ----------------------------------------
	// controller
	// ----------------------------------------
	reg        tpd_reg;
	wire       tapOn = tapEnableFuse & ~tpd_reg;
	wire [3:0] tapState;

	tap_fsm fsmInst (
		.core_clk  (core_clk),
		.srst      (srst),
		.hold      (~tapOn),
		.adv       (tckRise),
		.tms       (tmsS),
		.state_reg (tapState)
	);

	// ----------------------------------------
	// instruction and data registers
	// ----------------------------------------
	reg [`IR_W-1:0] ir_reg;
	reg [`IR_W-1:0] irShift_reg;
	reg             bypass_reg;
	reg [31:0]      idShift_reg;
	reg             resetBit_reg;
	reg [BS_LEN-1:0] bsShift_reg;
	reg [BS_LEN-1:0] bsLatch_reg;
	reg [BS_LEN-1:0] bsCapture;
	wire [1:0]      drSel = drSelect(ir_reg);
	wire [31:0]     idValue = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
	wire            extest = tapOn && (ir_reg == `OP_EXTEST);
	wire            bsMode = extest || (tapOn && (ir_reg == `OP_SAMPLE));
	integer         k, j;

	// pin input, present drive enable and analog interface
	always @* begin
		bsCapture = {BS_LEN{1'b0}};
		for (k = 0; k < PIN_COUNT; k = k + 1) begin
			bsCapture[2*k]   = pinSync[k];
			bsCapture[2*k+1] = pinOe[k];
		end
		bsCapture[BS_LEN-1:2*PIN_COUNT] = anaSync;
	end

	always @(posedge core_clk) begin
		if (srst || !tapOn) begin
			ir_reg       <= `OP_IDCODE;
			irShift_reg  <= `IR_CAPTURE;
			bypass_reg   <= 1'b0;
			idShift_reg  <= 32'h0000_0000;
			bsShift_reg  <= {BS_LEN{1'b0}};
			bsLatch_reg  <= {BS_LEN{1'b0}};
			resetBit_reg <= 1'b0;
		end else if (tckRise) begin
			// actions belong to the state being left
			case (tapState)
			`ST_TLR: begin
				ir_reg <= `OP_IDCODE;
			end
			`ST_CAPIR: begin
				irShift_reg <= `IR_CAPTURE;
			end
			`ST_SHIR: begin
				irShift_reg <= {tdiS, irShift_reg[`IR_W-1:1]};
			end
			`ST_UPIR: begin
				ir_reg <= irShift_reg;
			end
			`ST_CAPDR: begin
				case (drSel)
				`DR_ID:  idShift_reg <= idValue;
				`DR_BS:  bsShift_reg <= bsCapture;
				`DR_RST: ;
				default: bypass_reg <= 1'b0;
				endcase
			end
			`ST_SHDR: begin
				case (drSel)
				`DR_ID:  idShift_reg <= {tdiS, idShift_reg[31:1]};
				`DR_BS:  bsShift_reg <= {tdiS, bsShift_reg[BS_LEN-1:1]};
				`DR_RST: resetBit_reg <= tdiS;
				default: bypass_reg <= tdiS;
				endcase
			end
			`ST_UPDR: begin
				if (drSel == `DR_BS) begin
					bsLatch_reg <= bsShift_reg;
				end
			end
			default: ;
			endcase
		end
	end

	// output changes on the falling test clock edge
	always @(posedge core_clk) begin
		if (srst || !tapOn) begin
			tdo   <= 1'b0;
			tdoOe <= 1'b0;
		end else if (tckFall) begin
			tdoOe <= (tapState == `ST_SHIR) || (tapState == `ST_SHDR);
			if (tapState == `ST_SHIR) begin
				tdo <= irShift_reg[0];
			end else if (tapState == `ST_SHDR) begin
				case (drSel)
				`DR_ID:  tdo <= idShift_reg[0];
				`DR_BS:  tdo <= bsShift_reg[0];
				`DR_RST: tdo <= resetBit_reg;
				default: tdo <= bypass_reg;
				endcase
			end
		end
	end

	// ----------------------------------------
	// core reset and time-out
	// ----------------------------------------
	reg [23:0] toCnt_reg;

	always @(posedge core_clk) begin
		if (srst) begin
			toCnt_reg <= 24'h000000;
			coreReset <= 1'b0;
		end else begin
			// reload while held so the full time-out follows release
			if (resetBit_reg) begin
				toCnt_reg <= timeoutFuseLong ? TO_LONG_CYC : TO_SHORT_CYC;
			end else if (toCnt_reg != 24'h000000) begin
				toCnt_reg <= toCnt_reg - 24'h000001;
			end
			coreReset <= resetBit_reg || (toCnt_reg != 24'h000000);
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	reg [PIN_COUNT-1:0] pinOut_next;
	reg [PIN_COUNT-1:0] pinOe_next;

	always @* begin
		for (j = 0; j < PIN_COUNT; j = j + 1) begin
			if (extest) begin
				pinOut_next[j] = bsLatch_reg[2*j];
				pinOe_next[j]  = bsLatch_reg[2*j+1];
			end else begin
				pinOut_next[j] = coreOut[j];
				pinOe_next[j]  = coreOe[j] & ~coreReset;
			end
		end
	end

	// clocked on core_clk, so pins follow within a cycle
	always @(posedge core_clk) begin
		if (srst) begin
			pinOut        <= {PIN_COUNT{1'b0}};
			pinOe         <= {PIN_COUNT{1'b0}};
			anaOut        <= {ANA_COUNT{1'b0}};
			pullupDisable <= 1'b0;
		end else begin
			pinOut        <= pinOut_next;
			pinOe         <= pinOe_next;
			anaOut        <= extest ? bsLatch_reg[BS_LEN-1:2*PIN_COUNT] : coreAna;
			pullupDisable <= tapOn && bsMode;
		end
	end

	// ----------------------------------------
	// debug fuse guard
	// ----------------------------------------
	reg  lockLast_reg;
	reg  erased_reg;
	wire lockAny = lockBitOne | lockBitTwo;

	always @(posedge core_clk) begin
		if (srst) begin
			lockLast_reg     <= 1'b0;
			erased_reg       <= 1'b0;
			debugEnableFuse  <= 1'b0;
			debugFuseRefused <= 1'b0;
		end else begin
			lockLast_reg     <= lockAny;
			debugFuseRefused <= 1'b0;
			// erase in the same cycle as new locking wins
			if (chipErase) begin
				erased_reg <= 1'b1;
			end else if (lockAny && !lockLast_reg) begin
				erased_reg <= 1'b0;
			end
			if (debugFuseProgram) begin
				if (!lockAny || erased_reg) begin
					debugEnableFuse <= 1'b1;
				end else begin
					debugFuseRefused <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	reg [2:0] armCnt_reg;
	reg       armVal_reg;
	reg       rcFlag_reg;
	wire      ctrlWr = regWr && (regAddr == `REG_MCU_CTRL);
	wire      statWr = regWr && (regAddr == `REG_STATUS);

	always @(posedge core_clk) begin
		if (srst) begin
			tpd_reg    <= 1'b0;
			armCnt_reg <= 3'h0;
			armVal_reg <= 1'b0;
			rcFlag_reg <= 1'b0;
			regRdata   <= `RDATA_RESET;
		end else begin
			regRdata <= `RDATA_RESET;
			if (regRd) begin
				case (regAddr)
				`REG_MCU_CTRL: regRdata <= {tpd_reg, 7'h00};
				`REG_STATUS:   regRdata <= {1'b0, debugEnableFuse, coreReset, rcFlag_reg, ir_reg};
				default:       regRdata <= `RDATA_RESET;
				endcase
			end
			// accidental single writes cannot flip the disable bit
			if (ctrlWr) begin
				if (armCnt_reg != 3'h0 && regWdata[`CTRL_TPD_BIT] == armVal_reg) begin
					tpd_reg    <= armVal_reg;
					armCnt_reg <= 3'h0;
				end else begin
					armVal_reg <= regWdata[`CTRL_TPD_BIT];
					armCnt_reg <= `ARM_WINDOW;
				end
			end else if (armCnt_reg != 3'h0) begin
				armCnt_reg <= armCnt_reg - 3'h1;
			end
			// set by the reset chain wins over a software clear
			if (resetBit_reg) begin
				rcFlag_reg <= 1'b1;
			end else if (statWr && !regWdata[`STAT_RCF_BIT]) begin
				rcFlag_reg <= 1'b0;
			end
		end
	end
endmodule

// file: hw/tap_defs.vh
// constants for the boundary-scan test access logic
// Summary of operation
// - tap works only with enable fuse set and disable bit clear
// - instruction register is four bits, sixteen opcodes
// - all shift paths move least significant bit first, in and out
// - reset leaves identification opcode 0x1 selecting the 32-bit id register
// - id holds 4-bit version, 16-bit part number, 11-bit maker field
// - bypass is one stage, cleared when leaving capture-dr
// - opcode 0xF selects bypass; capture loads zero, shift shifts
// - opcode 0x0 selects chain; capture pins, shift, update drives pins
// - loading the external-test opcode drives latched outputs at once
// - chain covers control, data, input and analog interface; pull-up disable follows the opcode only
// - opcode 0x2 snapshots pins and preloads latches without touching pins
// - opcode 0xC selects one-bit reset register; tap state untouched
// - core held in reset while reset register holds one, unlatched
// - after release the core stays reset for the fuse-selected time-out
// - no high-impedance opcode; pins float whenever the core is reset, except under external test
// - scan needs core_clk running; the test clock is only sampled by it
// - lock bits block debug fuse programming until a chip erase
// - tap state machine starts in test-logic-reset after reset
// - five test clocks with mode select high reach test-logic-reset
// - shift-ir shifts out captured pattern 0x01
// - disable bit changes only on same value written twice in four cycles
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

`define IR_W          4
`define OP_EXTEST     4'h0
`define OP_IDCODE     4'h1
`define OP_SAMPLE     4'h2
`define OP_RSTCHAIN   4'hC
`define OP_BYPASS     4'hF
`define IR_CAPTURE    4'h1

`define DR_BYP        2'h0
`define DR_ID         2'h1
`define DR_BS         2'h2
`define DR_RST        2'h3

`define ST_TLR        4'h0
`define ST_RTI        4'h1
`define ST_SELDR      4'h2
`define ST_CAPDR      4'h3
`define ST_SHDR       4'h4
`define ST_EX1DR      4'h5
`define ST_PDR        4'h6
`define ST_EX2DR      4'h7
`define ST_UPDR       4'h8
`define ST_SELIR      4'h9
`define ST_CAPIR      4'hA
`define ST_SHIR       4'hB
`define ST_EX1IR      4'hC
`define ST_PIR        4'hD
`define ST_EX2IR      4'hE
`define ST_UPIR       4'hF

`define REG_MCU_CTRL  2'h0
`define REG_STATUS    2'h1
`define CTRL_TPD_BIT  7
`define STAT_RCF_BIT  4
`define STAT_CRST_BIT 5
`define STAT_DBG_BIT  6
`define RDATA_RESET   8'h00
`define ARM_WINDOW    3'h4

`define CORE_CLK_MHZ  25
`define TO_SHORT_US   65
`define TO_LONG_US    65000

`endif

// file: hw/tap_sync.v
// two-stage synchroniser for inputs from outside the core clock domain
`timescale 1ns/1ps
module tap_sync #(
	parameter WIDTH = 1
) (
	input  wire             core_clk,
	input  wire             srst,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always @(posedge core_clk) begin
		if (srst) begin
			meta_reg <= {WIDTH{1'b0}};
			q        <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// file: hw/tap_fsm.v
// sixteen-state test access port controller
`timescale 1ns/1ps
`include "tap_defs.vh"
module tap_fsm (
	input  wire       core_clk,
	input  wire       srst,
	input  wire       hold,
	input  wire       adv,
	input  wire       tms,
	output reg  [3:0] state_reg
);
	reg [3:0] state_next;

	always @* begin
		case (state_reg)
		`ST_TLR:   state_next = tms ? `ST_TLR   : `ST_RTI;
		`ST_RTI:   state_next = tms ? `ST_SELDR : `ST_RTI;
		`ST_SELDR: state_next = tms ? `ST_SELIR : `ST_CAPDR;
		`ST_CAPDR: state_next = tms ? `ST_EX1DR : `ST_SHDR;
		`ST_SHDR:  state_next = tms ? `ST_EX1DR : `ST_SHDR;
		`ST_EX1DR: state_next = tms ? `ST_UPDR  : `ST_PDR;
		`ST_PDR:   state_next = tms ? `ST_EX2DR : `ST_PDR;
		`ST_EX2DR: state_next = tms ? `ST_UPDR  : `ST_SHDR;
		`ST_UPDR:  state_next = tms ? `ST_SELDR : `ST_RTI;
		`ST_SELIR: state_next = tms ? `ST_TLR   : `ST_CAPIR;
		`ST_CAPIR: state_next = tms ? `ST_EX1IR : `ST_SHIR;
		`ST_SHIR:  state_next = tms ? `ST_EX1IR : `ST_SHIR;
		`ST_EX1IR: state_next = tms ? `ST_UPIR  : `ST_PIR;
		`ST_PIR:   state_next = tms ? `ST_EX2IR : `ST_PIR;
		`ST_EX2IR: state_next = tms ? `ST_UPIR  : `ST_SHIR;
		`ST_UPIR:  state_next = tms ? `ST_SELDR : `ST_RTI;
		default:   state_next = `ST_TLR;
		endcase
	end

	// advances only on a detected test clock rise
	always @(posedge core_clk) begin
		if (srst || hold) begin
			state_reg <= `ST_TLR;
		end else if (adv) begin
			state_reg <= state_next;
		end
	end
endmodule

// file: test/boundary_scan_tap_registers_chk.sv
// concurrent checks on the scan port and core-side outputs
`timescale 1ns/1ps
module boundary_scan_tap_registers_chk #(
	parameter PIN_COUNT = 8,
	parameter ANA_COUNT = 2
) (
	input wire                 core_clk,
	input wire                 srst,
	input wire                 tdoOe,
	input wire                 tapEnableFuse,
	input wire                 lockBitOne,
	input wire                 lockBitTwo,
	input wire                 debugFuseProgram,
	input wire                 regRd,
	input wire [7:0]           regRdata,
	input wire [PIN_COUNT-1:0] coreOut,
	input wire [PIN_COUNT-1:0] coreOe,
	input wire [PIN_COUNT-1:0] pinOut,
	input wire [PIN_COUNT-1:0] pinOe,
	input wire                 pullupDisable,
	input wire                 coreReset,
	input wire                 debugEnableFuse,
	input wire                 debugFuseRefused
);
	// ----
	// checks
	// ----
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	chk_off_no_drive: assert property (
		!tapEnableFuse [*3] |-> !tdoOe) else $error("tdo driven with tap disabled");
	chk_off_no_pullup: assert property (
		!tapEnableFuse [*3] |-> !pullupDisable) else $error("pull-up disabled with tap off");
	chk_refuse_pulse: assert property (
		debugFuseRefused |=> !debugFuseRefused) else $error("refusal longer than one cycle");
	chk_refuse_locked: assert property (
		debugFuseRefused |-> $past(debugFuseProgram) && ($past(lockBitOne) || $past(lockBitTwo)))
		else $error("refusal without locked request");
	chk_fuse_cause: assert property (
		$rose(debugEnableFuse) |-> $past(debugFuseProgram) && !debugFuseRefused)
		else $error("debug fuse set without request");
	chk_reset_float: assert property (
		coreReset && $past(coreReset) && !pullupDisable && !$past(pullupDisable) |-> pinOe == '0)
		else $error("pins driven during core reset");
	chk_core_pins: assert property (
		!$past(srst) && !$past(coreReset) && !pullupDisable && !$past(pullupDisable)
		|-> pinOe == $past(coreOe) && pinOut == $past(coreOut)) else $error("pins not from core");
	chk_rdata_slot: assert property (
		!$past(regRd) |-> regRdata == 8'h00) else $error("read data outside its slot");
endmodule
bind boundary_scan_tap_registers boundary_scan_tap_registers_chk #(
	.PIN_COUNT(PIN_COUNT),
	.ANA_COUNT(ANA_COUNT)
) i_boundary_scan_tap_registers_chk (
	.core_clk(core_clk), .srst(srst), .tdoOe(tdoOe), .tapEnableFuse(tapEnableFuse),
	.lockBitOne(lockBitOne), .lockBitTwo(lockBitTwo), .debugFuseProgram(debugFuseProgram),
	.regRd(regRd), .regRdata(regRdata), .coreOut(coreOut), .coreOe(coreOe), .pinOut(pinOut),
	.pinOe(pinOe), .pullupDisable(pullupDisable), .coreReset(coreReset),
	.debugEnableFuse(debugEnableFuse), .debugFuseRefused(debugFuseRefused)
);

// file: test/jtag_ctrl_model.sv
// model of the external test controller on the scan port
`timescale 1ns/1ps
module jtag_ctrl_model #(
	parameter HALF = 4
) (
	input  wire  core_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input  wire  tdo,
	input  wire  tdoOe
);
	// ----
	// test clock stays low between frames
	// ----
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	task automatic bitx(input logic m, input logic d, output logic o);
		@(posedge core_clk);
		tms <= m;
		tdi <= d;
		repeat (HALF - 1) @(posedge core_clk);
		// undriven line reads back inverted, so a silent port shows up
		o = tdoOe ? tdo : ~tdo;
		tck <= 1'b1;
		repeat (HALF) @(posedge core_clk);
		tck <= 1'b0;
	endtask
	// from idle: shift n bits, lsb first, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
		logic o;
		q = '0;
		bitx(1'b1, 1'b0, o);
		if (ir) bitx(1'b1, 1'b0, o);
		bitx(1'b0, 1'b0, o);
		bitx(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			bitx(i == n - 1, d[i], o);
			q[i] = o;
		end
		bitx(1'b1, 1'b0, o);
		bitx(1'b0, 1'b0, o);
		// one more edge so registered pins have settled
		@(posedge core_clk);
	endtask
	task automatic reset_tap();
		logic o;
		repeat (5) bitx(1'b1, 1'b0, o);
		bitx(1'b0, 1'b0, o);
	endtask
endmodule

// file: test/boundary_scan_tap_registers_test.sv
// self-checking bench for the boundary-scan registers
`timescale 1ns/1ps
module boundary_scan_tap_registers_test;
	// ----
	// setup
	// ----
	localparam logic [31:0] IDV = {4'h3, 16'hC0DE, 11'h155, 1'b1};
	localparam logic [17:0] PRE = 18'h296A5;
	localparam logic [17:0] EXD = 18'h15A0F;
	logic core_clk = 1'b0, srst = 1'b1, tck, tms, tdi, tdo, tdoOe, o;
	logic tapEnableFuse = 1'b1, lockBitOne = 1'b0, lockBitTwo = 1'b0, chipErase = 1'b0;
	logic debugFuseProgram = 1'b0, timeoutFuseLong = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [1:0] regAddr = 2'h0, anaIn = 2'h0, coreAna = 2'h0, anaOut;
	logic [7:0] regWdata = 8'h00, pinIn = 8'h00, coreOut = 8'h00, coreOe = 8'h00, regRdata, pinOut, pinOe, v;
	logic pullupDisable, coreReset, debugEnableFuse, debugFuseRefused;
	logic [31:0] q;
	logic [3:0] byOps [4] = '{4'hF, 4'h5, 4'h9, 4'hB};
	int n_errors = 0, total_checks = 0, cnt;
	always #20 core_clk = ~core_clk;
	// id values are arbitrary
	boundary_scan_tap_registers #(.ID_VERSION(4'h3), .ID_PART(16'hC0DE), .ID_MAKER(11'h155),
		.TO_SHORT_CYC(24'h28), .TO_LONG_CYC(24'h64)) i_boundary_scan_tap_registers (
		.core_clk(core_clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
		.tapEnableFuse(tapEnableFuse), .lockBitOne(lockBitOne), .lockBitTwo(lockBitTwo),
		.chipErase(chipErase), .debugFuseProgram(debugFuseProgram), .timeoutFuseLong(timeoutFuseLong),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.pinIn(pinIn), .coreOut(coreOut), .coreOe(coreOe), .pinOut(pinOut), .pinOe(pinOe),
		.pullupDisable(pullupDisable), .anaIn(anaIn), .coreAna(coreAna), .anaOut(anaOut),
		.coreReset(coreReset), .debugEnableFuse(debugEnableFuse), .debugFuseRefused(debugFuseRefused));
	jtag_ctrl_model i_jtag_ctrl_model (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdoOe(tdoOe));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(posedge core_clk);
		chk("register read", e, regRdata);
	endtask
	task automatic loadIr(input logic [3:0] op);
		i_jtag_ctrl_model.scan(1'b1, 4, {28'h0, op}, q);
		chk("ir capture", 32'h1, q);
	endtask
	task automatic progFuse(input logic erase);
		@(posedge core_clk);
		chipErase <= erase;
		debugFuseProgram <= ~erase;
		@(posedge core_clk);
		chipErase <= 1'b0;
		debugFuseProgram <= 1'b0;
	endtask
	function automatic logic [17:0] capt();
		logic [17:0] r;
		for (int i = 0; i < 8; i++) begin
			r[2*i] = pinIn[i];
			r[2*i+1] = coreOe[i];
		end
		r[17:16] = anaIn;
		return r;
	endfunction
	function automatic logic [17:0] latch(input logic [17:0] x);
		logic [17:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = x[2*i];
			r[8+i] = x[2*i+1];
		end
		r[17:16] = x[17:16];
		return r;
	endfunction
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(2'h1, 8'h01);
		rd(2'h2, 8'h00);
		i_jtag_ctrl_model.reset_tap();
		loadIr(4'h1);
		i_jtag_ctrl_model.scan(1'b0, 32, 32'h0, q);
		chk("idcode", IDV, q);
		foreach (byOps[k]) begin
			loadIr(byOps[k]);
			i_jtag_ctrl_model.scan(1'b0, 8, 32'hA5, q);
			chk("bypass", 32'h4A, q);
		end
		pinIn <= 8'h3C;
		coreOe <= 8'hF0;
		coreOut <= 8'h55;
		anaIn <= 2'h2;
		coreAna <= 2'h1;
		loadIr(4'h2);
		i_jtag_ctrl_model.scan(1'b0, 18, {14'h0, PRE}, q);
		chk("sample capture", {14'h0, capt()}, q);
		chk("pins untouched", {14'h0, coreAna, coreOe, coreOut}, {14'h0, anaOut, pinOe, pinOut});
		chk("pull-up off", 1, pullupDisable);
		loadIr(4'h0);
		chk("extest at once", latch(PRE), {anaOut, pinOe, pinOut});
		i_jtag_ctrl_model.scan(1'b0, 18, {14'h0, EXD}, q);
		chk("extest update", latch(EXD), {anaOut, pinOe, pinOut});
		loadIr(4'hC);
		i_jtag_ctrl_model.scan(1'b0, 1, 32'h1, q);
		chk("core reset", 1, coreReset);
		chk("pins float", 0, pinOe);
		rd(2'h1, 8'h3C);
		for (int f = 0; f < 2; f++) begin
			timeoutFuseLong <= f[0];
			i_jtag_ctrl_model.scan(1'b0, 1, 32'h1, q);
			i_jtag_ctrl_model.scan(1'b0, 1, 32'h0, q);
			for (cnt = 0; cnt < 200 && coreReset === 1'b1; cnt++) @(posedge core_clk);
			chk("reset hold", 1, f ? (cnt > 65 && cnt < 95) : (cnt > 5 && cnt < 35));
		end
		wr(2'h1, 8'h00);
		rd(2'h1, 8'h0C);
		loadIr(4'hF);
		i_jtag_ctrl_model.bitx(1'b1, 1'b0, o);
		i_jtag_ctrl_model.bitx(1'b0, 1'b0, o);
		i_jtag_ctrl_model.bitx(1'b0, 1'b0, o);
		i_jtag_ctrl_model.reset_tap();
		rd(2'h1, 8'h01);
		wr(2'h0, 8'h80);
		rd(2'h0, 8'h00);
		repeat (6) @(posedge core_clk);
		wr(2'h0, 8'h80);
		wr(2'h0, 8'h80);
		rd(2'h0, 8'h80);
		i_jtag_ctrl_model.scan(1'b1, 4, 32'hF, q);
		chk("port silent", 32'hF, q);
		rd(2'h1, 8'h01);
		wr(2'h0, 8'h00);
		wr(2'h0, 8'h00);
		tapEnableFuse <= 1'b0;
		i_jtag_ctrl_model.reset_tap();
		i_jtag_ctrl_model.scan(1'b1, 4, 32'hF, q);
		chk("fuse off silent", 32'hF, q);
		rd(2'h1, 8'h01);
		tapEnableFuse <= 1'b1;
		i_jtag_ctrl_model.reset_tap();
		loadIr(4'hF);
		rd(2'h1, 8'h0F);
		lockBitOne <= 1'b1;
		progFuse(1'b0);
		#1 chk("fuse refused", 2'b01, {debugEnableFuse, debugFuseRefused});
		progFuse(1'b1);
		progFuse(1'b0);
		#1 chk("fuse after erase", 2'b10, {debugEnableFuse, debugFuseRefused});
		end_of_test();
	end
	initial begin
		#3000000;
		n_errors++;
		end_of_test();
	end
endmodule
